// File: src/cow_option_decoder.sv
/*
 * code option word decoder: holds the two 13-bit option words written
 * by an external programmer, decodes word 0 into steady settings after
 * reset, makes the instruction cycle and timer enables, and gives
 * software an apb view of control and loader status only.
 * assumes programmer pins are asynchronous levels, apb on clk_in.
 */
`timescale 1ns/1ns
module cow_option_decoder (
   input  wire logic                         clk_in,
   input  wire logic                         nrst_in,
   // programmer pins
   input  wire logic                         prog_mode_in,
   input  wire logic                         prog_wr_in,
   input  wire logic                         prog_sel_in,
   input  wire logic [cow_pkg::WORD_W-1:0]   prog_data_in,
   output logic      [cow_pkg::WORD_W-1:0]   prog_rdata_out,
   // apb slave
   input  wire logic [cow_pkg::ADDR_W-1:0]   paddr_in,
   input  wire logic                         psel_in,
   input  wire logic                         penable_in,
   input  wire logic                         pwrite_in,
   input  wire logic [31:0]                  pwdata_in,
   input  wire logic [3:0]                   pstrb_in,
   output logic      [31:0]                  prdata_out,
   output logic                              pready_out,
   output logic                              pslverr_out,
   // decoded settings, cycle and timer enables
   output logic                              options_valid_out,
   output logic                              osc_type_select_out,
   output logic                              crystal_high_range_select_out,
   output logic                              osc_power_select_out,
   output logic                              rc_osc_mode_out,
   output logic                              high_crystal_mode_out,
   output logic                              low_crystal_mode_out,
   output logic                              watchdog_enable_out,
   output logic                              four_period_cycle_out,
   output logic                              code_protect_out,
   output logic                              cycle_tick_out,
   output logic                              timer_tick_out
);
   import cow_pkg::*;

   // ==========================================================
   // programmer pin synchronisers
   localparam int unsigned PIN_W = WORD_W + 3;

   logic [PIN_W-1:0] pin_s;
   logic             pmode_s;
   logic             pwr_s;
   logic             psel_s;
   logic [12:0]      pdata_s;
   logic             pwr_d_r;
   logic             wr_pulse;

   cow_sync #(.W(PIN_W)) u_sync (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .d_in    ({prog_mode_in, prog_wr_in, prog_sel_in, prog_data_in}),
      .q_out   (pin_s)
   );

   assign pmode_s = pin_s[PIN_W-1];
   assign pwr_s   = pin_s[PIN_W-2];
   assign psel_s  = pin_s[PIN_W-3];
   assign pdata_s = pin_s[WORD_W-1:0];

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pwr_d_r <= 1'b0;
      end else begin
         pwr_d_r <= pwr_s;
      end
   end

   assign wr_pulse = pwr_s && !pwr_d_r;

   // ==========================================================
   // loader state
   cow_state_t state_r;
   cow_state_t state_nxt;
   logic [1:0] settle_r;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         settle_r <= 2'h0;
      end else if (settle_r != SETTLE_LAST) begin
         settle_r <= settle_r + 2'h1;
      end
   end

   // once running, nothing moves until the next reset
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_prog: begin
            if (settle_r == SETTLE_LAST && !pmode_s) begin
               state_nxt = st_load;
            end
         end
         st_load: state_nxt = st_run;
         st_run:  state_nxt = st_run;
         default: state_nxt = st_prog;
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r <= st_prog;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // one-time storage, reachable only from the programmer pins
   logic [12:0] otp_word_r [NUM_WORDS];
   logic [1:0]  burnt_r;
   logic        prog_ok;

   assign prog_ok = (state_r == st_prog) && pmode_s && wr_pulse;

   // a second write to a word is ignored, as fuses only burn once
   genvar w;
   generate
      for (w = 0; w < NUM_WORDS; w++) begin : g_word
         always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               otp_word_r[w] <= BLANK_WORD;
               burnt_r[w]    <= 1'b0;
            end else if (prog_ok && !burnt_r[w] && psel_s == 1'(w)) begin
               otp_word_r[w] <= pdata_s;
               burnt_r[w]    <= 1'b1;
               if (w == 0) begin
                  otp_word_r[w][POS_RESERVED] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // both words, id bits included, go back only to the programmer for verify
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prog_rdata_out <= BLANK_WORD;
      end else begin
         prog_rdata_out <= otp_word_r[psel_s];
      end
   end

   // ==========================================================
   // decode of word 0, captured once in the load state
   logic [12:0] w0;
   logic        cfg_err_r;

   assign w0 = otp_word_r[0];

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         options_valid_out             <= 1'b0;
         osc_type_select_out           <= 1'b0;
         crystal_high_range_select_out <= 1'b0;
         osc_power_select_out          <= 1'b0;
         rc_osc_mode_out               <= 1'b0;
         high_crystal_mode_out         <= 1'b0;
         low_crystal_mode_out          <= 1'b0;
         watchdog_enable_out           <= 1'b0;
         four_period_cycle_out         <= 1'b0;
         code_protect_out              <= 1'b0;
         cfg_err_r                     <= 1'b0;
      end else if (state_r == st_load) begin
         options_valid_out   <= 1'b1;
         osc_type_select_out <= w0[POS_OSC_TYPE];
         crystal_high_range_select_out <=
            w0[POS_OSC_TYPE] && w0[POS_XTAL_RANGE];
         osc_power_select_out  <= w0[POS_OSC_POWER];
         rc_osc_mode_out       <= !w0[POS_OSC_TYPE];
         high_crystal_mode_out <=
            w0[POS_OSC_TYPE] && w0[POS_XTAL_RANGE];
         low_crystal_mode_out  <= w0[POS_OSC_TYPE]
            && !w0[POS_XTAL_RANGE] && !w0[POS_OSC_POWER];
         watchdog_enable_out   <= !w0[POS_WDT_DIS_N];
         four_period_cycle_out <= w0[POS_CYCLE_LEN];
         code_protect_out      <= !w0[POS_SECURE_N];
         // low range with high power has no mode; range set with rc keeps rc mode but is flagged too
         cfg_err_r <= (w0[POS_OSC_TYPE] && !w0[POS_XTAL_RANGE]
            && w0[POS_OSC_POWER])
            || (!w0[POS_OSC_TYPE] && w0[POS_XTAL_RANGE]);
      end
   end

   // ==========================================================
   // apb slave: control and status only, never the words
   logic       timer_en_r;
   logic       setup;
   logic       access;
   logic       hit_ctrl;
   logic       hit_stat;
   logic [31:0] rd_nxt;

   assign setup    = psel_in && !penable_in;
   assign access   = psel_in && penable_in && pready_out;
   assign hit_ctrl = paddr_in == OFF_CTRL;
   assign hit_stat = paddr_in == OFF_STATUS;

   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_nxt[CTRL_TIMER_EN] = timer_en_r;
      end else if (hit_stat) begin
         rd_nxt[STAT_VALID]   = options_valid_out;
         rd_nxt[STAT_CFG_ERR] = cfg_err_r;
         rd_nxt[STAT_PROG]    = state_r == st_prog;
      end
   end

   // one wait-free access phase: answer is ready the cycle after setup
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= setup;
         pslverr_out <= setup && !hit_ctrl && !hit_stat;
         prdata_out  <= (setup && !pwrite_in) ? rd_nxt
                                              : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         timer_en_r <= CTRL_RESET;
      end else if (access && pwrite_in && hit_ctrl && pstrb_in[0]) begin
         timer_en_r <= pwdata_in[CTRL_TIMER_EN];
      end
   end

   // ==========================================================
   // instruction cycle and timer enables
   cow_cycle_div u_div (
      .clk_in         (clk_in),
      .nrst_in        (nrst_in),
      .run_in         (state_r == st_run),
      .four_period_in (four_period_cycle_out),
      .timer_en_in    (timer_en_r),
      .cycle_tick_out (cycle_tick_out),
      .timer_tick_out (timer_tick_out)
   );

   // ==========================================================
   // checks
   a_valid_holds:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      options_valid_out |=> options_valid_out)
   else $error("options valid dropped");

   a_settings_fixed:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      options_valid_out |=> $stable({osc_type_select_out,
         watchdog_enable_out, four_period_cycle_out, code_protect_out,
         osc_power_select_out, low_crystal_mode_out}))
   else $error("decoded setting changed while running");

   a_no_tick_early:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      cycle_tick_out |-> options_valid_out)
   else $error("cycle tick before settings were valid");

   a_osc_type:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      options_valid_out |-> (rc_osc_mode_out == !w0[POS_OSC_TYPE])
         && (osc_type_select_out == w0[POS_OSC_TYPE]))
   else $error("oscillator type decode wrong");

   a_wdt_low_on:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      options_valid_out |-> watchdog_enable_out != w0[POS_WDT_DIS_N])
   else $error("watchdog enable polarity wrong");

   a_cycle_len:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      options_valid_out |-> four_period_cycle_out == w0[POS_CYCLE_LEN])
   else $error("cycle length decode wrong");

   a_security_low:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      options_valid_out |-> code_protect_out != w0[POS_SECURE_N])
   else $error("security polarity wrong");

   a_range_gated:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      (options_valid_out && !osc_type_select_out)
      |-> !crystal_high_range_select_out && !high_crystal_mode_out
         && !low_crystal_mode_out)
   else $error("crystal range active in rc mode");

   a_reserved_one:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      w0[POS_RESERVED])
   else $error("reserved option bit not one");

   a_power_level:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      options_valid_out |-> osc_power_select_out == w0[POS_OSC_POWER])
   else $error("power level decode wrong");

   a_mode_onehot:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      (options_valid_out && !cfg_err_r) |-> $onehot({rc_osc_mode_out,
         high_crystal_mode_out, low_crystal_mode_out}))
   else $error("oscillator mode not exactly one");

   a_apb_narrow:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      prdata_out[31:3] == 29'h0000_0000)
   else $error("apb read exposes more than status");

   a_apb_answer:
   assert property (@(posedge clk_in) disable iff (!nrst_in)
      (psel_in && !penable_in) |=> pready_out)
   else $error("apb answer not in first access cycle");

endmodule : cow_option_decoder

// File: src/cow_pkg.sv
/*
 * constants and types for the code option word decoder: word layout,
 * blank values, register map of the apb slave, loader states.
 * assumes nothing beyond a systemverilog compiler.
 */
package cow_pkg;

   // ==========================================================
   // option word layout
   localparam int unsigned WORD_W         = 13;
   localparam int unsigned NUM_WORDS      = 2;
   localparam logic [12:0] BLANK_WORD     = 13'h1fff;
   localparam int unsigned POS_OSC_TYPE   = 12;
   localparam int unsigned POS_WDT_DIS_N  = 11;
   localparam int unsigned POS_CYCLE_LEN  = 10;
   localparam int unsigned POS_SECURE_N   = 9;
   localparam int unsigned POS_XTAL_RANGE = 8;
   localparam int unsigned POS_RESERVED   = 7;
   localparam int unsigned POS_OSC_POWER  = 6;
   localparam int unsigned ID0_MSB        = 5;

   // ==========================================================
   // apb register map
   localparam int unsigned ADDR_W         = 12;
   localparam logic [11:0] OFF_CTRL       = 12'h000;
   localparam logic [11:0] OFF_STATUS     = 12'h004;
   localparam int unsigned CTRL_TIMER_EN  = 0;
   localparam logic        CTRL_RESET     = 1'h1;
   localparam int unsigned STAT_VALID     = 0;
   localparam int unsigned STAT_CFG_ERR   = 1;
   localparam int unsigned STAT_PROG      = 2;

   // ==========================================================
   // timing
   localparam logic [1:0]  SETTLE_LAST    = 2'h3;
   localparam logic [1:0]  SHORT_LAST     = 2'h1;
   localparam logic [1:0]  LONG_LAST      = 2'h3;

   typedef enum logic [1:0] {
      st_prog,
      st_load,
      st_run
   } cow_state_t;

endpackage : cow_pkg

// File: src/cow_sync.sv
/*
 * two flip-flop synchroniser, one chain per bit.
 * assumes the inputs are levels from outside the clock domain.
 */
`timescale 1ns/1ns
module cow_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               meta_r[i] <= 1'b0;
               q_out[i]  <= 1'b0;
            end else begin
               meta_r[i] <= d_in[i];
               q_out[i]  <= meta_r[i];
            end
         end
      end
   endgenerate

endmodule : cow_sync

// File: src/cow_cycle_div.sv
/*
 * instruction cycle divider: one-cycle enables at the cycle rate and
 * for the timer/counter unit, two or four clocks apart.
 * assumes the length select is static while run_in is high.
 */
`timescale 1ns/1ns
module cow_cycle_div (
   input  wire logic clk_in,
   input  wire logic nrst_in,
   input  wire logic run_in,
   input  wire logic four_period_in,
   input  wire logic timer_en_in,
   output logic      cycle_tick_out,
   output logic      timer_tick_out
);
   import cow_pkg::*;

   logic [1:0] cnt_r;
   logic [1:0] last;
   logic       wrap;

   assign last = four_period_in ? LONG_LAST : SHORT_LAST;
   assign wrap = run_in && (cnt_r >= last);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_r <= 2'h0;
      end else if (!run_in || wrap) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end

   // the timer source follows the cycle length, fosc/2 or fosc/4
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cycle_tick_out <= 1'b0;
         timer_tick_out <= 1'b0;
      end else begin
         cycle_tick_out <= wrap;
         timer_tick_out <= wrap && timer_en_in;
      end
   end

   a_timer_quarter:
   assert property (@(posedge clk_in)
      disable iff (!nrst_in || !timer_en_in || !run_in)
      (timer_tick_out && four_period_in)
      |=> (!timer_tick_out [*3] ##1 timer_tick_out))
   else $error("timer tick not every fourth clock");

   a_timer_half:
   assert property (@(posedge clk_in)
      disable iff (!nrst_in || !timer_en_in || !run_in)
      (timer_tick_out && !four_period_in)
      |=> (!timer_tick_out ##1 timer_tick_out))
   else $error("timer tick not every second clock");

endmodule : cow_cycle_div

// File: dv/cow_prog_model.sv
/*
 * programmer model: drives the option word pins of the decoder the way
 * an external device programmer would, one slow write per word.
 * assumes clk_in is the decoder clock; pins change after rising edges.
 */
`timescale 1ns/1ns
module cow_prog_model (
   input  wire logic        clk_in,
   output logic             mode_out,
   output logic             wr_out,
   output logic             sel_out,
   output logic [12:0]      data_out
);
   initial begin
      mode_out = 1'b1;
      wr_out   = 1'b0;
      sel_out  = 1'b0;
      data_out = 13'h0000;
   end

   // ==========================================================
   // mode pin
   task automatic set_mode(input logic m);
      @(posedge clk_in);
      mode_out <= m;
   endtask : set_mode

   // ==========================================================
   // burn one word
   // data and select settle well before the strobe, which is held
   // long enough for the synchroniser on the far side
   task automatic burn(input logic sel, input logic [12:0] d);
      @(posedge clk_in);
      sel_out  <= sel;
      // only the option word carries the range bit; the id word is free
      data_out <= sel ? d : {d[12:9], d[8] & d[12], d[7:0]};
      repeat (4) @(posedge clk_in);
      wr_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      wr_out <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask : burn
endmodule : cow_prog_model

// File: dv/cow_option_decoder_test.sv
/*
 * self-checking bench for the option word decoder: burns words through
 * the programmer model, loads them, checks decodes, ticks and apb.
 * assumes cow_pkg and the design files are compiled first.
 */
`timescale 1ns/1ns
module cow_option_decoder_test;
   import cow_pkg::*;
   logic        clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic        pmode, pwr, psl;
   logic [12:0] pdat, prd;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'h0;
   logic        pready, pslverr, valid, ctick, ttick, er;
   wire  [8:0]  dec;
   int          error_cnt = 0;
   int          tests_run = 0;
   logic [12:0] cfgs [4] = '{13'h002a, 13'h1d55, 13'h1215, 13'h1640};

   always #10 clk_in = ~clk_in;

   cow_prog_model u_prog (
      .clk_in   (clk_in),
      .mode_out (pmode),
      .wr_out   (pwr),
      .sel_out  (psl),
      .data_out (pdat)
   );

   cow_option_decoder u_dut (
      .clk_in                        (clk_in),
      .nrst_in                       (nrst_in),
      .prog_mode_in                  (pmode),
      .prog_wr_in                    (pwr),
      .prog_sel_in                   (psl),
      .prog_data_in                  (pdat),
      .prog_rdata_out                (prd),
      .paddr_in                      (paddr),
      .psel_in                       (psel),
      .penable_in                    (penable),
      .pwrite_in                     (pwrite),
      .pwdata_in                     (pwdata),
      .pstrb_in                      (pstrb),
      .prdata_out                    (prdata),
      .pready_out                    (pready),
      .pslverr_out                   (pslverr),
      .options_valid_out             (valid),
      .osc_type_select_out           (dec[8]),
      .crystal_high_range_select_out (dec[7]),
      .osc_power_select_out          (dec[6]),
      .rc_osc_mode_out               (dec[5]),
      .high_crystal_mode_out         (dec[4]),
      .low_crystal_mode_out          (dec[3]),
      .watchdog_enable_out           (dec[2]),
      .four_period_cycle_out         (dec[1]),
      .code_protect_out              (dec[0]),
      .cycle_tick_out                (ctick),
      .timer_tick_out                (ttick)
   );

   // ==========================================================
   // reporting
   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic timed_out();
      error_cnt++;
      print_verdict();
   endtask : timed_out

   // ==========================================================
   // apb master: no wait count assumed, bounded by the bench
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] wd, input logic [3:0] sb);
      int i;
      @(posedge clk_in);
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      pstrb   <= sb;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge clk_in);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
         timed_out();
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // expected decode, in the order of the dec bus
   function automatic logic [8:0] exp_dec(input logic [12:0] w);
      return {w[12], w[12] & w[8], w[6], ~w[12], w[12] & w[8],
              w[12] & ~w[8] & ~w[6], ~w[11], w[10], ~w[9]};
   endfunction : exp_dec

   // ==========================================================
   // scenarios
   task automatic t_reset();
      nrst_in <= 1'b0;
      u_prog.set_mode(1'b1);
      repeat (8) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      chk({22'h0, valid, dec}, 32'h0);
      chk({19'h0, prd}, 32'h1fff);
      apb(OFF_STATUS, 1'b0, 32'h0, 4'h0);
      chk(rd, 32'h4);
      apb(OFF_CTRL, 1'b0, 32'h0, 4'h0);
      chk(rd, 32'h1);
   endtask : t_reset

   task automatic t_burn(input logic [12:0] w0, input logic [12:0] w1);
      u_prog.burn(1'b0, w0);
      chk({19'h0, prd}, {19'h0, w0 | 13'h0080});
      u_prog.burn(1'b1, w1);
      chk({19'h0, prd}, {19'h0, w1});
      u_prog.burn(1'b0, ~w0 & 13'h0eff);
      chk({19'h0, prd}, {19'h0, w0 | 13'h0080});
   endtask : t_burn

   task automatic t_load(input logic [12:0] w0);
      int i;
      u_prog.set_mode(1'b0);
      i = 0;
      while (valid !== 1'b1 && i < 40) begin
         @(posedge clk_in);
         i++;
      end
      if (valid !== 1'b1)
         timed_out();
      chk({23'h0, dec}, {23'h0, exp_dec(w0)});
      apb(OFF_STATUS, 1'b1, 32'h0, 4'hf);
      chk({31'h0, er}, 32'h0);
      apb(OFF_STATUS, 1'b0, 32'h0, 4'h0);
      chk(rd, {30'h0, w0[12] & ~w0[8] & w0[6], 1'b1});
      apb(12'h008, 1'b0, 32'h0, 4'h0);
      chk({er, rd[30:0]}, 32'h80000000);
   endtask : t_load

   // count both ticks over 16 clocks, starting just after a cycle tick
   task automatic count_ticks(output int nc, output int nt);
      int i;
      i = 0;
      while (ctick !== 1'b1 && i < 20) begin
         @(posedge clk_in);
         i++;
      end
      if (ctick !== 1'b1)
         timed_out();
      nc = 0;
      nt = 0;
      repeat (16) begin
         @(posedge clk_in);
         nc += (ctick === 1'b1);
         nt += (ttick === 1'b1);
      end
   endtask : count_ticks

   task automatic t_ticks(input logic [12:0] w0);
      int nc, nt, ne;
      ne = w0[10] ? 4 : 8;
      count_ticks(nc, nt);
      chk(nc, ne);
      chk(nt, ne);
      apb(OFF_CTRL, 1'b1, 32'h0, 4'h1);
      apb(OFF_CTRL, 1'b1, 32'h1, 4'h0);
      count_ticks(nc, nt);
      chk(nc, ne);
      chk(nt, 0);
      apb(OFF_CTRL, 1'b1, 32'h1, 4'h1);
   endtask : t_ticks

   task automatic t_freeze(input logic [12:0] w0);
      u_prog.set_mode(1'b1);
      u_prog.burn(1'b0, ~w0 & 13'h1eff);
      chk({22'h0, valid, dec}, {23'h1, exp_dec(w0)});
      chk({19'h0, prd}, {19'h0, w0 | 13'h0080});
   endtask : t_freeze

   // ==========================================================
   // main sequence: each configuration starts from a fresh part
   initial begin
      foreach (cfgs[k]) begin
         t_reset();
         t_burn(cfgs[k], cfgs[k] ^ 13'h1a5c);
         t_load(cfgs[k]);
         t_ticks(cfgs[k]);
         t_freeze(cfgs[k]);
      end
      print_verdict();
   end
endmodule : cow_option_decoder_test
